/* File: hdl/isa_host_bus_decode.sv */
// isa host bus decoder: address decode, strobes, irq and dma routing
`timescale 1ns/100ps
`default_nettype none
module isa_host_bus_decode
	import isa_decode_pkg::*;
(
	input wire logic clk, // 250 mhz clock
	input wire logic rst_n, // async reset
	input wire isa_decode_pkg::pin_t pins, // isa pins, async
	input wire logic [4:0] man_sw, // manual base switches
	input wire isa_decode_pkg::cfg_t cfg, // pnp resources
	input wire isa_decode_pkg::irq_route_t [2:0] irq_route, // a, b, lpt
	input wire logic [2:0] core_irq, // a, b, lpt requests
	input wire logic [7:0] core_rdata, // read data from cores
	input wire logic lpt_wait, // printer needs time
	input wire logic lpt_dma_req, // printer wants dma
	input wire logic ecp_fifo_mode, // printer in ecp/fifo
	input wire logic dma_en, // dma channel enabled
	input wire logic [1:0] dma_sel, // 0,1,3,5 as 0..3
	output var isa_decode_pkg::acc_t acc, // access to cores
	output logic [7:0] d_o, // data bus out
	output logic d_oe, // data bus enable
	output logic [9:0] irq_o, // irq line levels
	output logic [9:0] irq_oe, // irq line enables
	output logic [3:0] dreq_o, // dma request levels
	output logic [3:0] dreq_oe, // dma request enables
	output logic iochrdy_o, // channel ready level
	output logic iochrdy_oe, // channel ready enable
	output logic dma_tc, // final dma transfer
	output logic dev_reset // reset to the cores
);
	import isa_decode_pkg::*;

	typedef struct packed {
		pin_t s1;
		pin_t s2;
		pin_t s3;
		pin_t v;
		acc_t acc;
		logic rd_act;
		logic [7:0] dout;
		logic [9:0] irq_o;
		logic [9:0] irq_oe;
		logic [3:0] dreq_o;
		logic [3:0] dreq_oe;
		logic rdy_oe;
		logic tc;
		logic dma_done;
		logic dev_rst;
	} state_t;

	state_t r;
	state_t n;
	tgt_t hit;
	logic ior_fall;
	logic ior_rise;
	logic iow_rise;
	logic ack;
	logic lpt_busy;

	// ****************************************
	// decode helpers
	// ****************************************

	// legacy com base, a10..a3
	function automatic logic [7:0] com_base(input logic [1:0] s);
		logic [10:0] b;
		b = COM1_BASE;
		case (s)
			2'd0: b = COM1_BASE;
			2'd1: b = COM2_BASE;
			2'd2: b = COM3_BASE;
			default: b = COM4_BASE;
		endcase
		return b[10:3];
	endfunction

	// map a sampled address to a target
	function automatic tgt_t decode(input pin_t p, input logic [4:0] sw,
			input cfg_t c);
		logic [7:0] ua;
		logic [7:0] ub;
		logic [10:0] lp;
		ua = c.ua_base;
		ub = c.ub_base;
		lp = {c.lpt_base, 2'b00};
		if (p.aen) begin
			return TGT_NONE;
		end
		if (p.manual_config_select_n) begin
			if (p.addr == PNP_ADDR_PORT || p.addr == PNP_WDATA_PORT ||
					p.addr == c.rd_port) begin
				return TGT_PNP;
			end
			if (!c.configured) begin
				return TGT_NONE;
			end
		end else begin
			// fixed bases from switches
			ua = com_base(sw[SW_COMA_LSB +: 2]);
			ub = com_base(sw[SW_COMB_LSB +: 2]);
			lp = sw[SW_LPT_BIT] ? LPT2_BASE : LPT1_BASE;
		end
		// only a10..a3 (a10..a2 for lpt) take part
		if (p.addr[10:3] == ua) begin
			return TGT_UART_A;
		end
		if (p.addr[10:3] == ub) begin
			return TGT_UART_B;
		end
		if (p.addr[10:2] == lp[10:2]) begin
			return TGT_LPT;
		end
		return TGT_NONE;
	endfunction

	// register index within the target
	function automatic logic [2:0] reg_idx(input tgt_t t,
			input logic [15:0] a);
		if (t == TGT_LPT) begin
			return {1'b0, a[1:0]};
		end
		return a[2:0];
	endfunction

	// ****************************************
	// next state
	// ****************************************

	// edges are seen between the filtered pin copies
	always_comb begin
		n = r;
		n.s1 = pins;
		n.s2 = r.s1;
		n.s3 = r.s2;
		// a bit moves once stages two and three agree
		n.v = (r.s2 & r.s3) | (r.v & (r.s2 | r.s3));
		ior_fall = r.v.ior_n & ~n.v.ior_n;
		ior_rise = ~r.v.ior_n & n.v.ior_n;
		iow_rise = ~r.v.iow_n & n.v.iow_n;
		ack = ~n.v.dack_n[dma_sel] & dma_en & ecp_fifo_mode;
		hit = decode(n.v, man_sw, cfg);
		n.acc.rd = 1'b0;
		n.acc.wr = 1'b0;
		n.acc.dma = 1'b0;
		n.tc = 1'b0;
		// host reads
		if (ior_fall) begin
			if (ack) begin
				n.acc.rd = 1'b1;
				n.acc.dma = 1'b1;
				n.acc.tgt = TGT_LPT;
				n.acc.idx = 3'd0;
				n.rd_act = 1'b1;
				n.tc = n.v.tc;
			end else if (hit != TGT_NONE) begin
				n.acc.rd = 1'b1;
				n.acc.tgt = hit;
				n.acc.idx = reg_idx(hit, n.v.addr);
				n.rd_act = 1'b1;
			end
		end
		if (ior_rise) begin
			n.rd_act = 1'b0;
		end
		// host writes, data taken at the rising strobe
		if (iow_rise) begin
			if (ack) begin
				n.acc.wr = 1'b1;
				n.acc.dma = 1'b1;
				n.acc.tgt = TGT_LPT;
				n.acc.idx = 3'd0;
				n.acc.wdata = n.v.dat;
				n.tc = n.v.tc;
			end else if (hit != TGT_NONE) begin
				n.acc.wr = 1'b1;
				n.acc.tgt = hit;
				n.acc.idx = reg_idx(hit, n.v.addr);
				n.acc.wdata = n.v.dat;
			end
		end
		// read data follows the cores every cycle outside pin reset, whatever the strobe level
		n.dout = core_rdata;
		// printer stall holds channel ready low
		lpt_busy = (~n.v.ior_n | ~n.v.iow_n) &
			(hit == TGT_LPT || ack);
		n.rdy_oe = lpt_wait & lpt_busy;
		// irq routing onto the ten host lines
		n.irq_o = 10'h000;
		n.irq_oe = 10'h000;
		for (int s = 0; s < 3; s++) begin
			for (int i = 0; i < IRQ_N; i++) begin
				if (irq_route[s].en && irq_route[s].sel == 4'(i)) begin
					n.irq_oe[i] = 1'b1;
					n.irq_o[i] = n.irq_o[i] | core_irq[s];
				end
			end
		end
		// dma request, blocked after terminal count
		if (!lpt_dma_req) begin
			n.dma_done = 1'b0;
		end
		if (n.tc) begin
			n.dma_done = 1'b1;
		end
		n.dreq_o = 4'h0;
		n.dreq_oe = 4'h0;
		n.dreq_oe[dma_sel] = dma_en & ecp_fifo_mode;
		n.dreq_o[dma_sel] = dma_en & ecp_fifo_mode &
			lpt_dma_req & ~n.dma_done;
		// pin reset clears all but the pin filters and dev_rst, which is set
		n.dev_rst = n.v.rst;
		if (n.v.rst) begin
			n.acc = '0;
			n.rd_act = 1'b0;
			n.dout = 8'h00;
			n.irq_o = 10'h000;
			n.irq_oe = 10'h000;
			n.dreq_o = 4'h0;
			n.dreq_oe = 4'h0;
			n.rdy_oe = 1'b0;
			n.tc = 1'b0;
			n.dma_done = 1'b0;
		end
	end

	// ****************************************
	// state register and outputs
	// ****************************************

	// one register for all state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.s1 <= PIN_IDLE;
			r.s2 <= PIN_IDLE;
			r.s3 <= PIN_IDLE;
			r.v <= PIN_IDLE;
		end else begin
			r <= n;
		end
	end

	assign acc = r.acc;
	assign d_o = r.dout;
	assign d_oe = r.rd_act;
	assign irq_o = r.irq_o;
	assign irq_oe = r.irq_oe;
	assign dreq_o = r.dreq_o;
	assign dreq_oe = r.dreq_oe;
	assign iochrdy_o = 1'b0;
	assign iochrdy_oe = r.rdy_oe;
	assign dma_tc = r.tc;
	assign dev_reset = r.dev_rst;

	// ****************************************
	// assertions
	// ****************************************

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_rd_on_fall;
		acc.rd |-> $fell(r.v.ior_n);
	endproperty
	a_rd_on_fall: assert property (p_rd_on_fall)
		else $error("read access without strobe fall");

	property p_wr_on_rise;
		acc.wr |-> $rose(r.v.iow_n) ##1 !acc.wr;
	endproperty
	a_wr_on_rise: assert property (p_wr_on_rise)
		else $error("write access not on strobe rise");

	property p_oe_read;
		d_oe |-> !r.v.ior_n;
	endproperty
	a_oe_read: assert property (p_oe_read)
		else $error("data driven outside a read");

	property p_aen_block;
		(acc.rd || acc.wr) && !acc.dma |-> !r.v.aen;
	endproperty
	a_aen_block: assert property (p_aen_block)
		else $error("access decoded while aen high");

	property p_uart_idx;
		acc.rd && acc.tgt == TGT_UART_A |-> acc.idx == r.v.addr[2:0];
	endproperty
	a_uart_idx: assert property (p_uart_idx)
		else $error("uart index not a0-a2");

	property p_lpt_idx;
		(acc.rd || acc.wr) && acc.tgt == TGT_LPT |-> !acc.idx[2];
	endproperty
	a_lpt_idx: assert property (p_lpt_idx)
		else $error("printer index uses a2");

	property p_irq_route;
		irq_route[0].en && irq_route[0].sel == 4'd2 && !r.v.rst &&
			!n.v.rst |=> irq_oe[2] && irq_o[2] == $past(core_irq[0]);
	endproperty
	a_irq_route: assert property (p_irq_route)
		else $error("irq line not following its source");

	property p_dreq_mode;
		|dreq_oe |-> $past(ecp_fifo_mode) && $past(dma_en);
	endproperty
	a_dreq_mode: assert property (p_dreq_mode)
		else $error("dma request outside ecp/fifo mode");

	property p_tc_end;
		dma_tc && lpt_dma_req |=> dreq_o == 4'h0;
	endproperty
	a_tc_end: assert property (p_tc_end)
		else $error("dma request after terminal count");

	property p_rdy_wait;
		iochrdy_oe |-> $past(lpt_wait) && iochrdy_o == 1'b0;
	endproperty
	a_rdy_wait: assert property (p_rdy_wait)
		else $error("channel ready pulled without wait");

	property p_rst_pin;
		r.v.rst |-> !d_oe && irq_oe == 10'h000 && dreq_oe == 4'h0;
	endproperty
	a_rst_pin: assert property (p_rst_pin)
		else $error("outputs active under pin reset");

	c_uart_rd: cover property (acc.rd && acc.tgt == TGT_UART_B);
	c_lpt_wr: cover property (acc.wr && acc.tgt == TGT_LPT);
	c_pnp: cover property (acc.wr && acc.tgt == TGT_PNP);
	c_dma_tc: cover property (dma_tc ##1 !(|dreq_o));
endmodule
`default_nettype wire

/* File: inc/isa_decode_pkg.sv */
// package: constants and carriers for the isa host bus decoder
package isa_decode_pkg;
	localparam int IRQ_N = 10;
	localparam int DMA_N = 4;
	// pnp auto configuration ports, full 16-bit match
	localparam logic [15:0] PNP_ADDR_PORT = 16'h0279;
	localparam logic [15:0] PNP_WDATA_PORT = 16'h0a79;
	// manual mode legacy bases, a0-a10
	localparam logic [10:0] COM1_BASE = 11'h03f8;
	localparam logic [10:0] COM2_BASE = 11'h02f8;
	localparam logic [10:0] COM3_BASE = 11'h03e8;
	localparam logic [10:0] COM4_BASE = 11'h02e8;
	localparam logic [10:0] LPT1_BASE = 11'h0378;
	localparam logic [10:0] LPT2_BASE = 11'h0278;
	// manual switch field positions
	localparam int SW_COMA_LSB = 0;
	localparam int SW_COMB_LSB = 2;
	localparam int SW_LPT_BIT = 4;
	// reset pulse minimum, and its cycle count at 250 mhz
	localparam int RST_MIN_NS = 40;
	localparam int CLK_NS = 4;
	localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
	typedef enum logic [2:0] {
		TGT_NONE, TGT_UART_A, TGT_UART_B, TGT_LPT, TGT_PNP
	} tgt_t;
	// isa pins as seen at the package boundary
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] dat;
		logic aen;
		logic ior_n;
		logic iow_n;
		logic tc;
		logic rst;
		logic manual_config_select_n;
		logic [3:0] dack_n;
	} pin_t;
	localparam pin_t PIN_IDLE = '{16'h0000, 8'h00, 1'b0, 1'b1, 1'b1,
		1'b0, 1'b0, 1'b1, 4'hf};
	// one register access handed to the cores
	typedef struct packed {
		logic rd;
		logic wr;
		logic dma;
		tgt_t tgt;
		logic [2:0] idx;
		logic [7:0] wdata;
	} acc_t;
	// pnp resource settings, bases as a10..a3 / a10..a2
	typedef struct packed {
		logic configured;
		logic [7:0] ua_base;
		logic [7:0] ub_base;
		logic [8:0] lpt_base;
		logic [15:0] rd_port;
	} cfg_t;
	typedef struct packed {
		logic en;
		logic [3:0] sel;
	} irq_route_t;
endpackage

/* File: tb/isa_host_model.sv */
// host cpu and dma controller model driving the isa pins
`timescale 1ns/100ps
`default_nettype none
module isa_host_model (
	input wire logic clk, // bench clock
	output var isa_decode_pkg::pin_t pins // isa pins toward the device
);
	import isa_decode_pkg::*;
	initial pins = PIN_IDLE;
	// one i/o cycle, each strobe level held well past the pin filter
	task automatic io(input logic [15:0] a, input logic wr, input logic [7:0] d, input logic dma_cyc);
		pins.addr = a;
		pins.aen = dma_cyc;
		pins.dat = d;
		@(posedge clk) #1;
		if (wr) pins.iow_n = 1'b0;
		else pins.ior_n = 1'b0;
		repeat (5) @(posedge clk);
		#1 pins.iow_n = 1'b1;
		pins.ior_n = 1'b1;
		repeat (5) @(posedge clk);
		#1 pins.aen = 1'b0;
		pins.dat = ~d; // released bus must not show the old byte
	endtask
	// dma cycle acknowledged on one channel, tc marks the last
	// dack and tc outlive the strobe so the rising write edge still sees them
	task automatic dma(input logic [1:0] ch, input logic last, input logic rd);
		@(posedge clk) #1;
		pins.aen = 1'b1;
		pins.dack_n[ch] = 1'b0;
		pins.tc = last;
		if (rd) pins.ior_n = 1'b0;
		else pins.iow_n = 1'b0;
		repeat (5) @(posedge clk);
		#1 pins.iow_n = 1'b1;
		pins.ior_n = 1'b1;
		repeat (5) @(posedge clk);
		#1 pins.dack_n = 4'hf;
		pins.tc = 1'b0;
		pins.aen = 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the isa host bus decoder
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import isa_decode_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	pin_t pins;
	logic [4:0] man_sw = 5'h04;
	cfg_t cfg = '0;
	irq_route_t [2:0] irq_route = '0;
	logic [2:0] core_irq = '0;
	logic [7:0] core_rdata = 8'h3c;
	logic lpt_wait = 1'b0, lpt_dma_req = 1'b0, ecp_fifo_mode = 1'b0, dma_en = 1'b0;
	logic [1:0] dma_sel = '0;
	acc_t acc, got;
	logic [7:0] d_o, dv;
	logic d_oe, iochrdy_o, iochrdy_oe, dma_tc, dev_reset, hit, rdy, tcs, oe_seen;
	logic [9:0] irq_o, irq_oe;
	logic [3:0] dreq_o, dreq_oe;
	int failures = 0, checks = 0;
	// free-running 250 mhz clock
	always #2 clk = ~clk;
	isa_host_model host (.clk(clk), .pins(pins));
	isa_host_bus_decode uut (.clk(clk), .rst_n(rst_n), .pins(pins), .man_sw(man_sw), .cfg(cfg),
		.irq_route(irq_route), .core_irq(core_irq), .core_rdata(core_rdata), .lpt_wait(lpt_wait),
		.lpt_dma_req(lpt_dma_req), .ecp_fifo_mode(ecp_fifo_mode), .dma_en(dma_en), .dma_sel(dma_sel),
		.acc(acc), .d_o(d_o), .d_oe(d_oe), .irq_o(irq_o), .irq_oe(irq_oe), .dreq_o(dreq_o),
		.dreq_oe(dreq_oe), .iochrdy_o(iochrdy_o), .iochrdy_oe(iochrdy_oe), .dma_tc(dma_tc),
		.dev_reset(dev_reset));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// bounded watch of the core side for one access
	task automatic watch();
		hit = 1'b0;
		rdy = 1'b0;
		tcs = 1'b0;
		oe_seen = 1'b0;
		got = '0;
		dv = '0;
		repeat (14) begin
			@(posedge clk) #1;
			if (iochrdy_oe && iochrdy_o === 1'b0) rdy = 1'b1;
			if (dma_tc) tcs = 1'b1;
			if (d_oe) begin
				oe_seen = 1'b1;
				dv = d_o;
			end
			if (!hit && (acc.rd || acc.wr)) begin
				hit = 1'b1;
				got = acc;
			end
		end
	endtask
	task automatic access(input logic [15:0] a, input logic wr, input logic aen, input logic eh, input tgt_t t,
			input logic [2:0] i);
		fork
			host.io(a, wr, 8'h5a, aen);
			watch();
		join
		chk(hit, eh);
		chk(oe_seen, eh && !wr);
		if (eh) chk({got.wr, got.dma, got.tgt}, {wr, 1'b0, t});
		if (eh && t != TGT_PNP) chk(got.idx, i);
		if (eh && wr) chk(got.wdata, 8'h5a);
		if (eh && !wr) chk(dv, core_rdata);
	endtask
	task automatic t_manual();
		host.pins.manual_config_select_n = 1'b0;
		access(16'h03fd, 0, 0, 1, TGT_UART_A, 3'h5);
		access(16'h02ff, 1, 0, 1, TGT_UART_B, 3'h7);
		lpt_wait = 1'b1;
		access(16'h037a, 0, 0, 1, TGT_LPT, 3'h2);
		chk(rdy, 1);
		lpt_wait = 1'b0;
		access(16'hf3f8, 0, 0, 1, TGT_UART_A, 3'h0);
		access(16'h0300, 0, 0, 0, TGT_NONE, 3'h0);
		access(16'h03fd, 0, 1, 0, TGT_NONE, 3'h0);
		$display("manual test done");
	endtask
	task automatic t_pnp();
		host.pins.manual_config_select_n = 1'b1;
		cfg = '{1'b1, 8'h7f, 8'h5f, 9'h0de, 16'h020b};
		access(16'h0a79, 1, 0, 1, TGT_PNP, 3'h0);
		access(16'h1a79, 1, 0, 0, TGT_NONE, 3'h0);
		access(16'h020b, 0, 0, 1, TGT_PNP, 3'h0);
		access(16'h03f9, 0, 0, 1, TGT_UART_A, 3'h1);
		access(16'h02fa, 0, 0, 1, TGT_UART_B, 3'h2);
		access(16'h037b, 1, 0, 1, TGT_LPT, 3'h3);
		$display("pnp test done");
	endtask
	task automatic t_irq();
		core_irq = 3'h2;
		for (int i = 0; i < 10; i++) begin
			irq_route[1] = '{1'b1, 4'(i)};
			repeat (3) @(posedge clk);
			#1 chk({irq_oe, irq_o}, {10'(1) << i, 10'(1) << i});
		end
		irq_route[1].en = 1'b0;
		repeat (3) @(posedge clk);
		#1 chk(irq_oe, 10'h000);
		$display("irq test done");
	endtask
	task automatic t_dma();
		ecp_fifo_mode = 1'b1;
		dma_en = 1'b1;
		// odd channels read, even channels write
		for (int s = 0; s < 4; s++) begin
			dma_sel = 2'(s);
			lpt_dma_req = 1'b1;
			repeat (3) @(posedge clk);
			#1 chk({dreq_oe, dreq_o}, {4'(1) << s, 4'(1) << s});
			fork
				host.dma(2'(s), 1'b1, s[0]);
				watch();
			join
			chk({hit, got.rd, got.wr, got.dma, got.tgt, tcs}, {1'b1, s[0], !s[0], 1'b1, TGT_LPT, 1'b1});
			chk(dreq_o, 4'h0);
			lpt_dma_req = 1'b0;
			repeat (3) @(posedge clk);
			#1;
		end
		lpt_dma_req = 1'b1;
		ecp_fifo_mode = 1'b0;
		repeat (3) @(posedge clk);
		#1 chk(dreq_oe, 4'h0);
		$display("dma test done");
	endtask
	task automatic t_reset();
		irq_route[0] = '{1'b1, 4'h2};
		core_irq = 3'h1;
		host.pins.rst = 1'b1;
		repeat (6) @(posedge clk);
		#1 chk({dev_reset, irq_oe, d_oe}, {1'b1, 10'h000, 1'b0});
		host.pins.rst = 1'b0;
		repeat (6) @(posedge clk);
		#1 chk({dev_reset, irq_oe, irq_o}, {1'b0, 10'h004, 10'h004});
		$display("reset test done");
	endtask
	// main sequence
	initial begin
		repeat (6) @(posedge clk);
		#1 rst_n = 1'b1;
		t_manual();
		t_pnp();
		t_irq();
		t_dma();
		t_reset();
		complete_run();
	end
	// hang guard
	initial begin
		#200000;
		failures++;
		complete_run();
	end
endmodule
`default_nettype wire
